// *** fttc_pkg.sv ***
// Constants and types of the field threshold and bias trim configuration block
// ----------------------------------------------------------------------------
// Operation
// - An 8-bit trim value, 0 to 255, sets the bias current reduction.
// - One enable per axis, X and Y; 1 trims that axis, 0 does not.
// - Both enables set: both axes get the same reduction, no imbalance correction.
// - Low flag when field is below low threshold; high flag when above high threshold.
// - Each flag switches with 6 mT hysteresis between rising and falling points.
// - Low and high thresholds are 3-bit codes in configuration register 6.
// - Codes 000 to 111 map to 26..126 mT rising, falling 6 mT lower.
// - A low code above the high code is accepted unchanged.
// - High flag at bit 7, low flag at bit 6 of status register 27.
// - Each flag's live state also drives its own output pin.
// - Frame after a read command returns the register in bits 15..8, flags in bits 15 and 14.
// - After reset the high code is 111 and the low code is 000.
// ----------------------------------------------------------------------------
package fttc_pkg;

   // ----------------------------------------------------------------------------
   // Register addresses (5-bit serial address space)
   // ----------------------------------------------------------------------------
   localparam logic [4:0] FTTC_ADDR_TRIM = 5'h02;
   localparam logic [4:0] FTTC_ADDR_AXIS = 5'h03;
   localparam logic [4:0] FTTC_ADDR_THRESH = 5'h06;
   localparam logic [4:0] FTTC_ADDR_STATUS = 5'h1b;

   // ----------------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------------
   localparam int FTTC_AXIS_X_BIT = 0;
   localparam int FTTC_AXIS_Y_BIT = 1;
   localparam int FTTC_LO_THR_LSB = 5;
   localparam int FTTC_HI_THR_LSB = 2;
   localparam int FTTC_HI_FLAG_BIT = 7;
   localparam int FTTC_LO_FLAG_BIT = 6;

   // ----------------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------------
   localparam logic [7:0] FTTC_TRIM_RESET = 8'h00;
   localparam logic [1:0] FTTC_AXIS_RESET = 2'h0;
   localparam logic [2:0] FTTC_LO_THR_RESET = 3'h0;
   localparam logic [2:0] FTTC_HI_THR_RESET = 3'h7;

   // ----------------------------------------------------------------------------
   // Serial command format: opcode in bits 15..13, address in 12..8, value 7..0
   // ----------------------------------------------------------------------------
   localparam logic [2:0] FTTC_OP_READ = 3'h2;
   localparam logic [2:0] FTTC_OP_WRITE = 3'h4;
   localparam logic [4:0] FTTC_FRAME_BITS = 5'h10;

   // ----------------------------------------------------------------------------
   // Field thresholds in mT: rising points per code, hysteresis below them
   // ----------------------------------------------------------------------------
   localparam logic [7:0] FTTC_HYST_MT = 8'h06;
   localparam logic [7:0] FTTC_RISE_MT [8] = '{8'h1a, 8'h29, 8'h38, 8'h46,
                                              8'h54, 8'h62, 8'h70, 8'h7e};

   // ----------------------------------------------------------------------------
   // Carried types
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] amount;
      logic x_en;
      logic y_en;
   } fttc_trim_t;

   typedef struct packed {
      logic [2:0] lo;
      logic [2:0] hi;
   } fttc_thresh_t;

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [2:0] cs_s;
      logic [2:0] mosi_s;
      logic sclk_f;
      logic cs_n_f;
      logic mosi_f;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [4:0] cnt;
      logic [15:0] resp;
      logic miso;
      logic miso_oe_n;
      fttc_trim_t trim;
      logic [7:0] x_amount;
      logic [7:0] y_amount;
      fttc_thresh_t thr;
      logic lo_flag;
      logic hi_flag;
   } fttc_state_t;

endpackage

// *** fttc_top.sv ***
// Serial register slave, bias trim outputs and field threshold flags
`timescale 1ns/100ps
module fttc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial pins from the host
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_n_o,
   // Measured field strength in mT, from the front end
   input wire logic [7:0] field_mt_i,
   // Bias trim to the sensing elements
   output logic [7:0] bias_trim_amount_o,
   output logic trim_x_axis_enable_o,
   output logic trim_y_axis_enable_o,
   output logic [7:0] trim_x_amount_o,
   output logic [7:0] trim_y_amount_o,
   // Field alarm pins
   output logic field_low_flag_o,
   output logic field_high_flag_o
);

   // ----------------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------------

   // Rising switching point of a threshold code
   function automatic logic [7:0] rise_mt(input logic [2:0] code);
      rise_mt = fttc_pkg::FTTC_RISE_MT[code];
   endfunction

   // Falling switching point, one hysteresis below the rising one
   function automatic logic [7:0] fall_mt(input logic [2:0] code);
      fall_mt = rise_mt(code) - fttc_pkg::FTTC_HYST_MT;
   endfunction

   // Register read mux
   function automatic logic [7:0] reg_read(input logic [4:0] addr,
                                           input fttc_pkg::fttc_state_t s);
      unique case (addr)
         fttc_pkg::FTTC_ADDR_TRIM: reg_read = s.trim.amount;
         fttc_pkg::FTTC_ADDR_AXIS: reg_read = {6'h00, s.trim.y_en, s.trim.x_en};
         fttc_pkg::FTTC_ADDR_THRESH: reg_read = {s.thr.lo, s.thr.hi, 2'h0};
         fttc_pkg::FTTC_ADDR_STATUS: reg_read = {s.hi_flag, s.lo_flag, 6'h00};
         default: reg_read = 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   fttc_pkg::fttc_state_t q;
   fttc_pkg::fttc_state_t d;

   logic sclk_rise;
   logic sclk_fall;
   logic frame_start;
   logic frame_end;
   logic [2:0] cmd_op;
   logic [4:0] cmd_addr;
   logic [7:0] cmd_val;

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb begin
      d = q;
      // Three-stage pin capture; a level counts once stages two and three agree
      d.sclk_s = {q.sclk_s[1:0], sclk_i};
      d.cs_s = {q.cs_s[1:0], cs_n_i};
      d.mosi_s = {q.mosi_s[1:0], mosi_i};
      if (q.sclk_s[1] == q.sclk_s[2]) begin
         d.sclk_f = q.sclk_s[2];
      end
      if (q.cs_s[1] == q.cs_s[2]) begin
         d.cs_n_f = q.cs_s[2];
      end
      if (q.mosi_s[1] == q.mosi_s[2]) begin
         d.mosi_f = q.mosi_s[2];
      end

      // Edges of the filtered levels
      sclk_rise = d.sclk_f & ~q.sclk_f & ~q.cs_n_f;
      sclk_fall = ~d.sclk_f & q.sclk_f & ~q.cs_n_f;
      frame_start = ~d.cs_n_f & q.cs_n_f;
      frame_end = d.cs_n_f & ~q.cs_n_f;

      // Frame start: previous answer goes out MSB first
      if (frame_start) begin
         d.tx = q.resp;
         d.miso = q.resp[15];
         d.miso_oe_n = 1'b0;
         d.cnt = 5'h00;
         d.rx = 16'h0000;
      end

      // Sample on rising clock, shift out on falling clock
      if (sclk_rise) begin
         d.rx = {q.rx[14:0], q.mosi_f};
         if (q.cnt != fttc_pkg::FTTC_FRAME_BITS) begin
            d.cnt = q.cnt + 5'h01;
         end
      end
      if (sclk_fall) begin
         d.tx = {q.tx[14:0], 1'b0};
         d.miso = q.tx[14];
      end

      // Command decode when a full frame ends
      cmd_op = q.rx[15:13];
      cmd_addr = q.rx[12:8];
      cmd_val = q.rx[7:0];
      if (frame_end) begin
         d.miso = 1'b0;
         d.miso_oe_n = 1'b1;
         d.resp = 16'h0000;
         if (q.cnt == fttc_pkg::FTTC_FRAME_BITS) begin
            if (cmd_op == fttc_pkg::FTTC_OP_WRITE) begin
               unique case (cmd_addr)
                  fttc_pkg::FTTC_ADDR_TRIM: begin
                     d.trim.amount = cmd_val;
                  end
                  fttc_pkg::FTTC_ADDR_AXIS: begin
                     d.trim.x_en = cmd_val[fttc_pkg::FTTC_AXIS_X_BIT];
                     d.trim.y_en = cmd_val[fttc_pkg::FTTC_AXIS_Y_BIT];
                  end
                  fttc_pkg::FTTC_ADDR_THRESH: begin
                     // Any pair of codes is kept as written
                     d.thr.lo = cmd_val[fttc_pkg::FTTC_LO_THR_LSB +: 3];
                     d.thr.hi = cmd_val[fttc_pkg::FTTC_HI_THR_LSB +: 3];
                  end
                  // Status and unmapped addresses ignore writes
                  default: begin
                  end
               endcase
               d.resp = {reg_read(cmd_addr, d), 8'h00};
            end else if (cmd_op == fttc_pkg::FTTC_OP_READ) begin
               d.resp = {reg_read(cmd_addr, q), 8'h00};
            end
         end
      end

      // Per-axis trim; both enabled gives equal reduction on both axes
      d.x_amount = q.trim.x_en ? q.trim.amount : 8'h00;
      d.y_amount = q.trim.y_en ? q.trim.amount : 8'h00;

      // High flag: set above rising point, clear below falling point
      if (field_mt_i >= rise_mt(q.thr.hi)) begin
         d.hi_flag = 1'b1;
      end else if (field_mt_i < fall_mt(q.thr.hi)) begin
         d.hi_flag = 1'b0;
      end
      // Low flag: set below falling point, clear above rising point
      if (field_mt_i < fall_mt(q.thr.lo)) begin
         d.lo_flag = 1'b1;
      end else if (field_mt_i >= rise_mt(q.thr.lo)) begin
         d.lo_flag = 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.cs_s <= 3'h7;
         q.cs_n_f <= 1'b1;
         q.miso_oe_n <= 1'b1;
         q.trim.amount <= fttc_pkg::FTTC_TRIM_RESET;
         q.trim.x_en <= fttc_pkg::FTTC_AXIS_RESET[0];
         q.trim.y_en <= fttc_pkg::FTTC_AXIS_RESET[1];
         q.thr.lo <= fttc_pkg::FTTC_LO_THR_RESET;
         q.thr.hi <= fttc_pkg::FTTC_HI_THR_RESET;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------------------
   assign miso_o = q.miso;
   assign miso_oe_n_o = q.miso_oe_n;
   assign bias_trim_amount_o = q.trim.amount;
   assign trim_x_axis_enable_o = q.trim.x_en;
   assign trim_y_axis_enable_o = q.trim.y_en;
   assign trim_x_amount_o = q.x_amount;
   assign trim_y_amount_o = q.y_amount;
   assign field_low_flag_o = q.lo_flag;
   assign field_high_flag_o = q.hi_flag;

endmodule // fttc_top

// *** fttc_host.sv ***
// Host controller model driving the serial register pins
`timescale 1ns/100ps
module fttc_host (
   // Clock
   input wire logic clk_i,
   // Serial pins
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic miso_oe_n_i
);
   // Pin level: pull-down while the device releases it
   wire miso_w = miso_oe_n_i ? 1'b0 : miso_i;
   // Idle: deselected, clock low, data pulled down
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // One 16-bit frame, MSB first, phases of six cycles
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
      cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = cmd[i];
         repeat (6) @(negedge clk_i);
         sclk_o = 1'b1;
         rsp[i] = miso_w;
         repeat (6) @(negedge clk_i);
         sclk_o = 1'b0;
      end
      repeat (6) @(negedge clk_i);
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      repeat (8) @(negedge clk_i);
   endtask
endmodule // fttc_host

// *** fttc_chk_asserts.sv ***
// Concurrent checks of trim outputs, field flags and serial pins
`timescale 1ns/100ps
module fttc_chk (
   // Clock, reset and serial pins
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_n_o,
   // Field input and outputs
   input wire logic [7:0] field_mt_i,
   input wire logic [7:0] bias_trim_amount_o,
   input wire logic trim_x_axis_enable_o,
   input wire logic trim_y_axis_enable_o,
   input wire logic [7:0] trim_x_amount_o,
   input wire logic [7:0] trim_y_amount_o,
   input wire logic field_low_flag_o,
   input wire logic field_high_flag_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Frame opened and bus left idle
   sequence s_open;
      $fell(cs_n_i) ##1 !cs_n_i [*4];
   endsequence
   sequence s_idle;
      cs_n_i [*8];
   endsequence
   property p_x_on;
      trim_x_axis_enable_o |=> trim_x_amount_o == $past(bias_trim_amount_o);
   endproperty
   a_x_on: assert property (p_x_on) else $error("x amount differs");
   property p_x_off;
      !trim_x_axis_enable_o |=> trim_x_amount_o == 8'h00;
   endproperty
   a_x_off: assert property (p_x_off) else $error("x trimmed while off");
   property p_y_on;
      trim_y_axis_enable_o |=> trim_y_amount_o == $past(bias_trim_amount_o);
   endproperty
   a_y_on: assert property (p_y_on) else $error("y amount differs");
   property p_both;
      trim_x_axis_enable_o && trim_y_axis_enable_o |=> trim_x_amount_o == trim_y_amount_o;
   endproperty
   a_both: assert property (p_both) else $error("axes differ");
   property p_hi;
      field_mt_i >= 8'd126 |=> field_high_flag_o && !field_low_flag_o;
   endproperty
   a_hi: assert property (p_hi) else $error("strong field flags wrong");
   property p_lo;
      field_mt_i < 8'd20 |=> field_low_flag_o && !field_high_flag_o;
   endproperty
   a_lo: assert property (p_lo) else $error("weak field flags wrong");
   property p_open;
      s_open |=> !miso_oe_n_o;
   endproperty
   a_open: assert property (p_open) else $error("miso not driven in frame");
   property p_idle;
      s_idle |-> miso_oe_n_o && !miso_o && $stable(bias_trim_amount_o);
   endproperty
   a_idle: assert property (p_idle) else $error("activity while idle");
endmodule // fttc_chk
bind fttc_top fttc_chk u_chk (.*);

// *** tb.sv ***
// Self-checking testbench of the field threshold and bias trim block
`timescale 1ns/100ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] field_mt_i = 8'h40;
   logic sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o, field_low_flag_o, field_high_flag_o;
   logic trim_x_axis_enable_o, trim_y_axis_enable_o;
   logic [7:0] bias_trim_amount_o, trim_x_amount_o, trim_y_amount_o;
   logic [15:0] rsp;
   int mismatches = 0;
   int tests_run = 0;
   // Clock of 100 ns
   always #50 clk_i = ~clk_i;
   fttc_top uut (.*);
   fttc_host host (.clk_i(clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i),
      .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o));
   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      host.xfer({fttc_pkg::FTTC_OP_WRITE, a, v}, rsp);
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] r);
      host.xfer({fttc_pkg::FTTC_OP_READ, a, 8'h00}, r);
      host.xfer(16'h0000, r);
   endtask
   // Field step, then the alarm pins {high, low}
   task automatic lvl(input int f, input logic [1:0] exp);
      field_mt_i = f[7:0];
      repeat (3) @(negedge clk_i);
      check({14'h0, field_high_flag_o, field_low_flag_o}, {14'h0, exp}, "flag pins");
   endtask
   task automatic t_defaults();
      rd(fttc_pkg::FTTC_ADDR_THRESH, rsp);
      check(rsp, 16'h1c00, "thresholds at reset");
      rd(fttc_pkg::FTTC_ADDR_TRIM, rsp);
      check(rsp, 16'h0000, "trim at reset");
      check({14'h0, trim_x_axis_enable_o, trim_y_axis_enable_o}, 16'h0, "axes at reset");
      rd(5'h1f, rsp);
      check(rsp, 16'h0000, "unmapped read");
   endtask
   task automatic t_trim();
      wr(fttc_pkg::FTTC_ADDR_TRIM, 8'h81);
      wr(fttc_pkg::FTTC_ADDR_AXIS, 8'h01);
      check({trim_x_amount_o, trim_y_amount_o}, 16'h8100, "x only");
      wr(fttc_pkg::FTTC_ADDR_AXIS, 8'h03);
      check({trim_x_amount_o, trim_y_amount_o}, 16'h8181, "both axes");
      wr(fttc_pkg::FTTC_ADDR_TRIM, 8'hff);
      wr(fttc_pkg::FTTC_ADDR_AXIS, 8'h02);
      check({trim_x_amount_o, trim_y_amount_o}, 16'h00ff, "y only");
      rd(fttc_pkg::FTTC_ADDR_TRIM, rsp);
      check(rsp, 16'hff00, "trim readback");
   endtask
   task automatic t_flags();
      field_mt_i = 8'd30;
      wr(fttc_pkg::FTTC_ADDR_THRESH, 8'he3);
      rd(fttc_pkg::FTTC_ADDR_THRESH, rsp);
      check(rsp, 16'he000, "low code above high");
      rd(fttc_pkg::FTTC_ADDR_STATUS, rsp);
      check(rsp, 16'hc000, "status flags");
      check({14'h0, field_high_flag_o, field_low_flag_o}, 16'h0003, "pins");
      wr(fttc_pkg::FTTC_ADDR_STATUS, 8'h00);
      rd(fttc_pkg::FTTC_ADDR_STATUS, rsp);
      check(rsp, 16'hc000, "status after write");
   endtask
   task automatic t_levels();
      int rise [8] = '{26, 41, 56, 70, 84, 98, 112, 126};
      for (int c = 0; c < 8; c++) begin
         wr(fttc_pkg::FTTC_ADDR_THRESH, {3'h0, c[2:0], 2'h0});
         lvl(rise[c] - 7, {1'b0, (c == 0)});
         lvl(rise[c] - 1, {1'b0, (c == 0)});
         lvl(rise[c], 2'b10);
         lvl(rise[c] - 6, 2'b10);
      end
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      t_defaults();
      t_trim();
      t_flags();
      t_levels();
      finish_test();
   end
   // Watchdog
   initial begin
      #3000000;
      mismatches++;
      finish_test();
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
endmodule // tb
